// ---- shared/sfbp_defines.svh ----
// Constants for the serial flash boot protocol, with the operation summary.
// Operation
// - Serial mode needs strap and mode pin high
// - Host clocks device 20 cycles in reset
// - Host alone makes the transfer clock
// - Device samples receive line on rising edge
// - Device changes transmit line on falling edge
// - Bytes of eight bits, LSB first
// - Busy low when ready, high while working
// - Host waits for busy low per byte
// - Commands arrive as bytes, opcode first
// - Non-blank flash needs seven-byte ID match
// - Blank flash accepts every command; program and erase only while no error is set
// - Without match only status, ID, version
// - Only user area is ever rewritten
// - Middle then zero high address byte
// - Page read returns 256 ascending bytes
// - Status command returns flash then link status
// - Version command returns bytes two to nine
// - Download sends size, checksum, then data
// - Page program writes 256 ascending bytes
// - Erase all needs confirmation byte first
// - ID check sends address, length, code
// - Downloaded program runs only on checksum match
`ifndef SFBP_DEFINES_SVH
`define SFBP_DEFINES_SVH
// ==========================================
// Timing
`define SFBP_CLK_NS        40
`define SFBP_SCLK_HALF_NS  160
`define SFBP_SCLK_HALF_CYC ((`SFBP_SCLK_HALF_NS + `SFBP_CLK_NS - 1) / `SFBP_CLK_NS)
`define SFBP_RST_HOLD_CYC  20
`define SFBP_WORK_CYC      64
// ==========================================
// Opcodes
`define SFBP_OP_READ  8'hFF
`define SFBP_OP_PROG  8'h41
`define SFBP_OP_ERASE 8'hA7
`define SFBP_OP_CONF  8'hD0
`define SFBP_OP_STAT  8'h70
`define SFBP_OP_CLR   8'h50
`define SFBP_OP_ID    8'hF5
`define SFBP_OP_DL    8'hFA
`define SFBP_OP_VER   8'hFB
// ==========================================
// Memory layout
`define SFBP_FLASH_BYTES 4096
`define SFBP_BOOT_PAGES  4'h4
`define SFBP_RAM_BYTES   256
`define SFBP_ID_PAGE     8'hFF
`define SFBP_ID_BASE     16'h00D4
`define SFBP_ID_LEN      7
`define SFBP_PAGE_LAST   9'h101
// Version text is arbitrary; byte 0 sits in the low bits.
`define SFBP_VERSION     64'h3030_2E31_2052_4556
// ==========================================
// Status bit positions
`define SFBP_FS_READY     7
`define SFBP_FS_ERASE_ERR 5
`define SFBP_FS_PROG_ERR  4
`define SFBP_LS_BOOT_DONE 7
`define SFBP_LS_SUM_OK    4
`define SFBP_LS_ID_HI     3
`define SFBP_LS_ID_LO     2
`endif

// ---- shared/sfbp_pkg.sv ----
// Types shared by both ends of the serial flash boot link.
package sfbp_pkg;
  typedef logic [7:0] sfbp_byte_t;
  typedef enum logic [2:0] {
    ST_CMD  = 3'h1,
    ST_XFER = 3'h2,
    ST_WORK = 3'h4
  } sfbp_dev_state_e;
  typedef enum logic [4:0] {
    HS_RST  = 5'h01,
    HS_IDLE = 5'h02,
    HS_WAIT = 5'h04,
    HS_LOW  = 5'h08,
    HS_HIGH = 5'h10
  } sfbp_host_state_e;
endpackage

// ---- shared/sfbp_if.sv ----
// Four-wire serial link between programmer and device.
`timescale 1ns/1ps
interface sfbp_if;
  logic sclk;
  logic rxd;
  logic txd;
  logic busy;
  modport dev  (input sclk, input rxd, output txd, output busy);
  modport host (output sclk, output rxd, input txd, input busy);
endinterface

// ---- hw/sfbp_sync.sv ----
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/1ps
module sfbp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// ---- hw/sfbp_host.sv ----
// Programmer end: reset sequencing and byte transfers over the serial link.
`timescale 1ns/1ps
`include "sfbp_defines.svh"
module sfbp_host
  import sfbp_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  sfbp_if.host            LINK,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_BYTE,
  output logic            TX_READY,
  output logic            RX_VALID,
  output logic      [7:0] RX_BYTE,
  output logic            DEV_RST_B,
  output logic            BOOT_STRAP_OUT,
  output logic            MODE_VOLT_OUT
);
  logic [1:0]       in_s;
  sfbp_host_state_e state_reg;
  sfbp_byte_t       tx_sh_reg;
  sfbp_byte_t       rx_sh_reg;
  sfbp_byte_t       rx_byte_reg;
  logic [2:0]       bit_reg;
  logic [4:0]       cnt_reg;
  logic             sclk_reg;
  logic             rxd_reg;
  logic             rx_valid_reg;
  logic             dev_rst_b_reg;

  // ==========================================
  // Synchronised busy and transmit line
  sfbp_sync #(.W(2)) u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({LINK.busy, LINK.txd}),
    .q     (in_s)
  );

  wire       busy_s   = in_s[1];
  wire       txd_s    = in_s[0];
  wire       half_end = cnt_reg == 5'(`SFBP_SCLK_HALF_CYC - 1);
  wire       hold_end = cnt_reg == 5'(`SFBP_RST_HOLD_CYC - 1);
  wire [2:0] bit_nx   = bit_reg + 3'h1;
  wire [7:0] rx_nx    = {txd_s, rx_sh_reg[7:1]};

  // ==========================================
  // Sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      state_reg     <= HS_RST;
      cnt_reg       <= 5'h00;
      sclk_reg      <= 1'b1;
      rxd_reg       <= 1'b1;
      bit_reg       <= 3'h0;
      tx_sh_reg     <= 8'h00;
      rx_sh_reg     <= 8'h00;
      rx_byte_reg   <= 8'h00;
      rx_valid_reg  <= 1'b0;
      dev_rst_b_reg <= 1'b0;
    end
    else
    begin
      rx_valid_reg <= 1'b0;
      unique case (state_reg)
        HS_RST:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (hold_end)
          begin
            cnt_reg       <= 5'h00;
            dev_rst_b_reg <= 1'b1;
            state_reg     <= HS_IDLE;
          end
        end
        HS_IDLE:
        begin
          if (TX_VALID)
          begin
            tx_sh_reg <= TX_BYTE;
            state_reg <= HS_WAIT;
          end
        end
        HS_WAIT:
        begin
          if (!busy_s)
          begin
            sclk_reg  <= 1'b0;
            rxd_reg   <= tx_sh_reg[0];
            bit_reg   <= 3'h0;
            cnt_reg   <= 5'h00;
            state_reg <= HS_LOW;
          end
        end
        HS_LOW:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (half_end)
          begin
            cnt_reg   <= 5'h00;
            sclk_reg  <= 1'b1;
            state_reg <= HS_HIGH;
          end
        end
        HS_HIGH:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (half_end)
          begin
            cnt_reg   <= 5'h00;
            rx_sh_reg <= rx_nx;
            if (bit_reg == 3'h7)
            begin
              rx_byte_reg  <= rx_nx;
              rx_valid_reg <= 1'b1;
              state_reg    <= HS_IDLE;
            end
            else
            begin
              bit_reg   <= bit_nx;
              sclk_reg  <= 1'b0;
              rxd_reg   <= tx_sh_reg[bit_nx];
              state_reg <= HS_LOW;
            end
          end
        end
      endcase
    end
  end

  assign LINK.sclk      = sclk_reg;
  assign LINK.rxd       = rxd_reg;
  assign TX_READY       = state_reg == HS_IDLE;
  assign RX_VALID       = rx_valid_reg;
  assign RX_BYTE        = rx_byte_reg;
  assign DEV_RST_B      = dev_rst_b_reg;
  assign BOOT_STRAP_OUT = 1'b1;
  assign MODE_VOLT_OUT  = 1'b1;
endmodule

// ---- hw/sfbp_dev.sv ----
// Device end: boot-mode command interpreter with flash and download memory.
`timescale 1ns/1ps
`include "sfbp_defines.svh"
module sfbp_dev
  import sfbp_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       BOOT_STRAP,
  input  wire logic       MODE_VOLT,
  sfbp_if.dev             LINK,
  output logic            SERIAL_MODE,
  output logic            DL_RUN,
  input  wire logic [7:0] DL_ADDR,
  output logic      [7:0] DL_DATA
);
  logic [3:0]      in_s;
  logic [1:0]      arm_reg;
  logic            mode_reg;
  logic            sclk_d_reg;
  logic [2:0]      bit_reg;
  sfbp_byte_t      rx_sh_reg;
  sfbp_byte_t      tx_reg;
  logic            txd_reg;
  logic            busy_reg;
  sfbp_dev_state_e state_reg;
  sfbp_byte_t      cmd_reg;
  sfbp_byte_t      addr_reg;
  sfbp_byte_t      chk_reg;
  sfbp_byte_t      sum_reg;
  sfbp_byte_t      idlen_reg;
  logic [8:0]      cnt_reg;
  logic [15:0]     idx_reg;
  logic [15:0]     size_reg;
  logic [15:0]     work_reg;
  logic [15:0]     valid_reg;
  logic [1:0]      err_reg;
  logic            erase_reg;
  logic            id_run_reg;
  logic            id_ok_reg;
  logic            sum_ok_reg;
  logic            boot_done_reg;
  logic            dl_run_reg;
  sfbp_byte_t      dl_data_reg;
  sfbp_byte_t      fs_view;
  sfbp_byte_t      ls_view;
  sfbp_byte_t      flash_mem [0:`SFBP_FLASH_BYTES-1];
  sfbp_byte_t      ram_mem [0:`SFBP_RAM_BYTES-1];

  // ==========================================
  // Input synchronisers and link edges
  sfbp_sync #(.W(4)) u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({BOOT_STRAP, MODE_VOLT, LINK.sclk, LINK.rxd}),
    .q     (in_s)
  );

  wire        sclk_rise = in_s[1] & ~sclk_d_reg;
  wire        sclk_fall = ~in_s[1] & sclk_d_reg;
  wire        byte_done = mode_reg & sclk_rise & (bit_reg == 3'h7);
  wire [7:0]  rx_byte   = {in_s[0], rx_sh_reg[7:1]};
  wire        is_xfer   = state_reg == ST_XFER;
  wire [7:0]  fl_idx    = (cnt_reg == 9'h001) ? 8'h00 : idx_reg[7:0];
  wire [11:0] fl_addr   = {addr_reg[3:0], fl_idx};
  wire [7:0]  flash_q   = valid_reg[addr_reg[3:0]] ? flash_mem[fl_addr] : 8'hFF;
  wire        blank     = ~|valid_reg;
  wire        gate_ok   = blank | id_ok_reg;
  wire        user_page = addr_reg[3:0] >= `SFBP_BOOT_PAGES;
  wire [63:0] ver_w     = `SFBP_VERSION;
  wire [2:0]  ver_i     = cnt_reg[2:0] + 3'h1;
  wire [7:0]  ver_nx    = ver_w[{ver_i, 3'h0} +: 8];
  wire        data_ph   = cnt_reg >= 9'h002;
  wire        dl_ph     = cnt_reg >= 9'h003;
  wire [15:0] idx_nx    = idx_reg + 16'h0001;
  wire        dl_last   = idx_nx == size_reg;
  wire [7:0]  sum_nx    = sum_reg + rx_byte;
  wire        id_hit    = (rx_byte == flash_q) & (cnt_reg - 9'h004 < 9'(`SFBP_ID_LEN));
  wire        id_last   = cnt_reg == {1'b0, idlen_reg} + 9'h003;
  wire [8:0]  cnt_nx    = (cnt_reg == 9'h1FF) ? cnt_reg : cnt_reg + 9'h001;
  wire        op_open   = (rx_byte == `SFBP_OP_STAT) | (rx_byte == `SFBP_OP_VER)
                        | (rx_byte == `SFBP_OP_ID);
  wire        op_wr     = (rx_byte == `SFBP_OP_PROG) | (rx_byte == `SFBP_OP_ERASE);
  wire        op_gated  = gate_ok & ((rx_byte == `SFBP_OP_READ) | (rx_byte == `SFBP_OP_DL)
                        | (~|err_reg & op_wr));
  wire        fl_we     = is_xfer & byte_done & (cmd_reg == `SFBP_OP_PROG) & data_ph & user_page;
  wire        ram_we    = is_xfer & byte_done & (cmd_reg == `SFBP_OP_DL) & dl_ph
                        & (idx_reg < 16'(`SFBP_RAM_BYTES));

  always_comb
  begin
    fs_view                     = 8'h00;
    fs_view[`SFBP_FS_READY]     = state_reg != ST_WORK;
    fs_view[`SFBP_FS_ERASE_ERR] = err_reg[1];
    fs_view[`SFBP_FS_PROG_ERR]  = err_reg[0];
    ls_view                     = 8'h00;
    ls_view[`SFBP_LS_BOOT_DONE] = boot_done_reg;
    ls_view[`SFBP_LS_SUM_OK]    = sum_ok_reg;
    ls_view[`SFBP_LS_ID_HI]     = id_ok_reg;
    ls_view[`SFBP_LS_ID_LO]     = id_ok_reg;
  end

  // ==========================================
  // Memories
  always_ff @(posedge REF_CLK)
  begin
    if (fl_we)
      flash_mem[fl_addr] <= rx_byte;
    if (ram_we)
      ram_mem[idx_reg[7:0]] <= rx_byte;
    dl_data_reg <= ram_mem[DL_ADDR];
  end

  // ==========================================
  // Mode entry and bit engine
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      arm_reg  <= 2'h0;
      mode_reg <= 1'b0;
    end
    else if (arm_reg != 2'h3)
    begin
      arm_reg <= arm_reg + 2'h1;
      if (arm_reg == 2'h2)
        mode_reg <= in_s[3] & in_s[2];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      sclk_d_reg <= 1'b1;
      bit_reg    <= 3'h0;
      rx_sh_reg  <= 8'h00;
      txd_reg    <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= in_s[1];
      if (mode_reg && sclk_fall)
        txd_reg <= tx_reg[bit_reg];
      if (mode_reg && sclk_rise)
      begin
        rx_sh_reg <= rx_byte;
        bit_reg   <= bit_reg + 3'h1;
      end
    end
  end

  // ==========================================
  // Command interpreter
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      state_reg     <= ST_CMD;
      busy_reg      <= 1'b0;
      tx_reg        <= 8'h00;
      cmd_reg       <= 8'h00;
      addr_reg      <= 8'h00;
      chk_reg       <= 8'h00;
      sum_reg       <= 8'h00;
      idlen_reg     <= 8'h00;
      cnt_reg       <= 9'h000;
      idx_reg       <= 16'h0000;
      size_reg      <= 16'h0000;
      work_reg      <= 16'h0000;
      valid_reg     <= 16'h0000;
      err_reg       <= 2'h0;
      erase_reg     <= 1'b0;
      id_run_reg    <= 1'b0;
      id_ok_reg     <= 1'b0;
      sum_ok_reg    <= 1'b0;
      boot_done_reg <= 1'b0;
      dl_run_reg    <= 1'b0;
    end
    else
    begin
      dl_run_reg <= 1'b0;
      if (mode_reg && sclk_fall && bit_reg == 3'h0)
        busy_reg <= 1'b1;
      unique case (state_reg)
        ST_CMD:
        begin
          if (byte_done)
          begin
            busy_reg <= 1'b0;
            cmd_reg  <= rx_byte;
            cnt_reg  <= 9'h000;
            if (op_open || op_gated)
              state_reg <= ST_XFER;
            if (rx_byte == `SFBP_OP_STAT)
              tx_reg <= fs_view;
            if (rx_byte == `SFBP_OP_VER)
              tx_reg <= ver_w[7:0];
            if (gate_ok && rx_byte == `SFBP_OP_CLR)
            begin
              err_reg       <= 2'h0;
              sum_ok_reg    <= 1'b0;
              boot_done_reg <= 1'b0;
            end
          end
        end
        ST_XFER:
        begin
          if (byte_done)
          begin
            busy_reg <= 1'b0;
            cnt_reg  <= cnt_nx;
            unique case (cmd_reg)
              `SFBP_OP_STAT:
              begin
                tx_reg <= ls_view;
                if (cnt_reg == 9'h001)
                  state_reg <= ST_CMD;
              end
              `SFBP_OP_VER:
              begin
                tx_reg <= ver_nx;
                if (cnt_reg == 9'h007)
                  state_reg <= ST_CMD;
              end
              `SFBP_OP_READ, `SFBP_OP_PROG:
              begin
                if (cnt_reg == 9'h000)
                  addr_reg <= rx_byte;
                if (cnt_reg == 9'h001)
                  idx_reg <= 16'h0000;
                if (cnt_reg >= 9'h001)
                begin
                  tx_reg  <= flash_q;
                  idx_reg <= (cnt_reg == 9'h001) ? 16'h0001 : idx_nx;
                end
                if (cmd_reg == `SFBP_OP_PROG && cnt_reg == 9'h001)
                  idx_reg <= 16'h0000;
                if (cmd_reg == `SFBP_OP_PROG && data_ph)
                  idx_reg <= idx_nx;
                if (cnt_reg == `SFBP_PAGE_LAST)
                begin
                  state_reg <= (cmd_reg == `SFBP_OP_PROG) ? ST_WORK : ST_CMD;
                  busy_reg  <= cmd_reg == `SFBP_OP_PROG;
                  erase_reg <= 1'b0;
                  work_reg  <= 16'(`SFBP_WORK_CYC - 1);
                end
              end
              `SFBP_OP_ERASE:
              begin
                state_reg <= ST_CMD;
                if (rx_byte == `SFBP_OP_CONF)
                begin
                  state_reg <= ST_WORK;
                  busy_reg  <= 1'b1;
                  erase_reg <= 1'b1;
                  work_reg  <= 16'(`SFBP_WORK_CYC - 1);
                end
                else
                  err_reg <= 2'h3;
              end
              `SFBP_OP_ID:
              begin
                if (cnt_reg == 9'h003)
                begin
                  idlen_reg  <= rx_byte;
                  addr_reg   <= `SFBP_ID_PAGE;
                  idx_reg    <= `SFBP_ID_BASE;
                  id_run_reg <= rx_byte == 8'(`SFBP_ID_LEN);
                  if (rx_byte == 8'h00)
                  begin
                    id_ok_reg <= 1'b0;
                    state_reg <= ST_CMD;
                  end
                end
                if (cnt_reg >= 9'h004)
                begin
                  idx_reg    <= idx_nx;
                  id_run_reg <= id_run_reg & id_hit;
                  if (id_last)
                  begin
                    id_ok_reg <= id_run_reg & id_hit;
                    state_reg <= ST_CMD;
                  end
                end
              end
              `SFBP_OP_DL:
              begin
                if (cnt_reg == 9'h000)
                  size_reg[7:0] <= rx_byte;
                if (cnt_reg == 9'h001)
                  size_reg[15:8] <= rx_byte;
                if (cnt_reg == 9'h002)
                begin
                  chk_reg <= rx_byte;
                  sum_reg <= 8'h00;
                  idx_reg <= 16'h0000;
                  if (size_reg == 16'h0000)
                  begin
                    sum_ok_reg    <= rx_byte == 8'h00;
                    boot_done_reg <= rx_byte == 8'h00;
                    dl_run_reg    <= rx_byte == 8'h00;
                    state_reg     <= ST_CMD;
                  end
                end
                if (dl_ph)
                begin
                  sum_reg <= sum_nx;
                  idx_reg <= idx_nx;
                  if (dl_last)
                  begin
                    sum_ok_reg    <= sum_nx == chk_reg;
                    boot_done_reg <= sum_nx == chk_reg;
                    dl_run_reg    <= sum_nx == chk_reg;
                    state_reg     <= ST_CMD;
                  end
                end
              end
              default:
                state_reg <= ST_CMD;
            endcase
          end
        end
        ST_WORK:
        begin
          work_reg <= work_reg - 16'h0001;
          if (work_reg == 16'h0000)
          begin
            state_reg <= ST_CMD;
            busy_reg  <= 1'b0;
            if (erase_reg)
              valid_reg <= 16'h0000;
            else if (user_page)
              valid_reg[addr_reg[3:0]] <= 1'b1;
            else
              err_reg[0] <= 1'b1;
          end
        end
      endcase
    end
  end

  assign LINK.txd    = txd_reg;
  assign LINK.busy   = busy_reg | ~mode_reg;
  assign SERIAL_MODE = mode_reg;
  assign DL_RUN      = dl_run_reg;
  assign DL_DATA     = dl_data_reg;
endmodule

// ---- tb/sfbp_properties.sv ----
// Concurrent checks on the serial link between programmer and device.
`timescale 1ns/1ps
module sfbp_properties (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic sclk,
  input wire logic rxd,
  input wire logic txd,
  input wire logic busy
);
  // ==========================================
  // Count of transfer clock falls within a byte.
  logic       sclk_q_reg;
  logic [2:0] falls_reg;
  logic [2:0] falls_next;
  logic       fall_seen;
  assign fall_seen  = sclk_q_reg && !sclk;
  assign falls_next = fall_seen ? falls_reg + 3'h1 : falls_reg;
  always_ff @(posedge REF_CLK)
  begin
    sclk_q_reg <= RST_B ? sclk : 1'b1;
    falls_reg  <= RST_B ? falls_next : 3'h0;
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  // ==========================================
  // Link checks.
  property p_rxd_hold;
    sclk && $past(sclk) |-> $stable(rxd);
  endproperty
  a_rxd_hold:
    assert property (p_rxd_hold) else $error("rxd moved while sclk high");
  property p_txd_fall;
    $changed(txd) |-> !sclk;
  endproperty
  a_txd_fall:
    assert property (p_txd_fall) else $error("txd moved while sclk high");
  property p_low_len;
    $fell(sclk) |-> (!sclk) [*4] ##1 sclk;
  endproperty
  a_low_len:
    assert property (p_low_len) else $error("sclk low phase not four cycles");
  property p_high_len;
    $rose(sclk) |-> sclk [*4];
  endproperty
  a_high_len:
    assert property (p_high_len) else $error("sclk high phase too short");
  property p_busy_rise;
    $fell(sclk) && falls_reg == 3'h0 |-> ##[1:6] busy;
  endproperty
  a_busy_rise:
    assert property (p_busy_rise) else $error("busy did not rise at byte start");
  property p_start_ready;
    $fell(sclk) && falls_reg == 3'h0 |-> !busy;
  endproperty
  a_start_ready:
    assert property (p_start_ready) else $error("byte started while busy");
  property p_busy_mid;
    $fell(sclk) && falls_reg != 3'h0 |-> busy;
  endproperty
  a_busy_mid:
    assert property (p_busy_mid) else $error("busy low inside a byte");
  property p_busy_drop;
    $fell(busy) |-> sclk && falls_reg == 3'h0;
  endproperty
  a_busy_drop:
    assert property (p_busy_drop) else $error("busy fell before eight bits");
endmodule

// ---- tb/test_serial_flash_boot_protocol.sv ----
// Self-checking bench for both ends of the serial flash boot link.
`timescale 1ns/1ps
`include "sfbp_defines.svh"
module test_serial_flash_boot_protocol
  import sfbp_pkg::*;
;
  logic       clk;
  logic       rst_b;
  logic       strap;
  logic       volt;
  logic       tx_valid;
  sfbp_byte_t tx_byte;
  logic       tx_ready;
  logic       rx_valid;
  sfbp_byte_t rx_byte;
  logic       dev_rst_b;
  logic       serial_mode;
  logic       dl_run;
  sfbp_byte_t dl_addr;
  sfbp_byte_t dl_data;
  sfbp_byte_t pg [256];
  sfbp_byte_t fs;
  sfbp_byte_t ls;
  sfbp_byte_t r;
  logic [63:0] ver = `SFBP_VERSION;
  sfbp_byte_t ops [5] = '{`SFBP_OP_READ, `SFBP_OP_PROG, `SFBP_OP_ERASE, `SFBP_OP_CLR,
                          `SFBP_OP_DL};
  int         bad_count = 0;
  int         checks = 0;
  int         runs = 0;
  sfbp_if     link ();
  sfbp_host sfbp_host_i (.REF_CLK(clk), .RST_B(rst_b), .LINK(link.host), .TX_VALID(tx_valid),
    .TX_BYTE(tx_byte), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .DEV_RST_B(dev_rst_b), .BOOT_STRAP_OUT(), .MODE_VOLT_OUT());
  sfbp_dev sfbp_dev_i (.REF_CLK(clk), .RST_B(dev_rst_b), .BOOT_STRAP(strap), .MODE_VOLT(volt),
    .LINK(link.dev), .SERIAL_MODE(serial_mode), .DL_RUN(dl_run), .DL_ADDR(dl_addr),
    .DL_DATA(dl_data));
  sfbp_properties sfbp_properties_i (.REF_CLK(clk), .RST_B(rst_b), .sclk(link.sclk),
    .rxd(link.rxd), .txd(link.txd), .busy(link.busy));
  always #20 clk = ~clk;
  always @(posedge clk) if (dl_run === 1'b1) runs++;
  // ==========================================
  // Helpers.
  task automatic chk(input sfbp_byte_t got, input sfbp_byte_t exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic xfer(input sfbp_byte_t b);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) bad_count++;
    tx_valid = 1'b1;
    tx_byte  = b;
    @(posedge clk);
    #1;
    tx_valid = 1'b0;
    n = 0;
    while (rx_valid !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) bad_count++;
    r = rx_byte;
  endtask
  task automatic stat();
    xfer(`SFBP_OP_STAT);
    xfer(8'h00);
    fs = r;
    xfer(8'h00);
    ls = r;
  endtask
  task automatic rst(input logic s, input logic v);
    rst_b = 1'b0;
    strap = s;
    volt  = v;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (18) @(posedge clk);
    #1;
    chk({7'h00, dev_rst_b}, 8'h00);
    repeat (22) @(posedge clk);
    #1;
    chk({7'h00, serial_mode}, {7'h00, s & v});
    chk({7'h00, link.busy}, {7'h00, ~(s & v)});
  endtask
  task automatic prog(input sfbp_byte_t p);
    xfer(`SFBP_OP_PROG);
    xfer(p);
    xfer(8'h00);
    for (int i = 0; i < 256; i++) xfer(pg[i]);
  endtask
  task automatic idc(input logic bad);
    xfer(`SFBP_OP_ID);
    xfer(8'hD4);
    xfer(8'hFF);
    xfer(8'h00);
    xfer(8'h07);
    for (int i = 0; i < 7; i++) xfer(pg[8'hD4 + i] ^ {7'h00, bad && i == 3});
  endtask
  function automatic sfbp_byte_t sum_of(input int n);
    sfbp_byte_t s;
    s = 8'h00;
    for (int i = 0; i < n; i++) s += pg[i];
    return s;
  endfunction
  task automatic dl(input int n, input sfbp_byte_t e);
    xfer(`SFBP_OP_DL);
    xfer(8'(n));
    xfer(8'(n >> 8));
    xfer(sum_of(n) + e);
    for (int i = 0; i < n; i++) xfer(pg[i]);
    stat();
  endtask
  // ==========================================
  // Main sequence.
  initial
  begin
    clk      = 1'b0;
    rst_b    = 1'b0;
    strap    = 1'b0;
    volt     = 1'b0;
    tx_valid = 1'b0;
    tx_byte  = 8'h00;
    dl_addr  = 8'h00;
    r = 8'($urandom(32'hB03745F5));
    for (int i = 0; i < 4; i++) rst(i[1], i[0]);
    stat();
    chk(fs, 8'h80);
    chk(ls, 8'h00);
    xfer(`SFBP_OP_ERASE);
    xfer(8'h55);
    stat();
    chk(fs, 8'hB0);
    xfer(`SFBP_OP_CLR);
    stat();
    chk(fs, 8'h80);
    for (int i = 0; i < 256; i++) pg[i] = 8'($urandom);
    prog(8'h0F);
    stat();
    chk(fs, 8'h80);
    for (int k = 0; k < 5; k++)
    begin
      xfer(ops[k]);
      chk({7'h00, link.busy}, 8'h00);
      stat();
      chk(fs, 8'h80);
      chk(ls, 8'h00);
    end
    xfer(`SFBP_OP_VER);
    for (int i = 0; i < 8; i++)
    begin
      xfer(8'h00);
      chk(r, ver[8 * i +: 8]);
    end
    idc(1'b1);
    stat();
    chk(ls, 8'h00);
    idc(1'b0);
    stat();
    chk(ls, 8'h0C);
    xfer(`SFBP_OP_READ);
    xfer(8'h0F);
    xfer(8'h00);
    for (int i = 0; i < 256; i++)
    begin
      xfer(8'h00);
      chk(r, pg[i]);
    end
    prog(8'h02);
    stat();
    chk(fs, 8'h90);
    xfer(`SFBP_OP_CLR);
    stat();
    chk(fs, 8'h80);
    xfer(`SFBP_OP_ERASE);
    xfer(`SFBP_OP_CONF);
    stat();
    chk(fs, 8'h80);
    dl(16, 8'h01);
    chk(ls & 8'h10, 8'h00);
    chk(8'(runs), 8'h00);
    dl(16, 8'h00);
    chk(ls & 8'h10, 8'h10);
    chk(8'(runs), 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      dl_addr = 8'(i);
      @(posedge clk);
      #1;
      chk(dl_data, pg[i]);
    end
    test_done();
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
